// ==== dv/ioscc_top_sva.sv ====
`timescale 1ns/1ps
module ioscc_top_sva
   import ioscc_pkg::*;
#(
   parameter int SLOW_DIV = 3200,
   parameter int FAST_DIV = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // configuration
   input wire logic [3:0] primary_mode,
   input wire logic [1:0] clock_group_sel,
   input wire logic power_managed,
   // steering
   input wire logic [4:0] fast_osc_trim,
   input wire logic [4:0] slow_rc_trim,
   input wire logic mul_run,
   input wire logic [2:0] dev_freq_sel,
   input wire logic lf_from_fast,
   input wire logic [3:0] dev_mult,
   input wire logic [1:0] dev_group,
   input wire logic secondary_run,
   input wire logic special_from_slow,
   input wire logic exec_hold
);
   // ----------------------------------------
   // age of the last trim write
   // ----------------------------------------
   logic [4:0] trim_last;
   int age;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         trim_last <= 5'h00;
         age <= 0;
      end else if (reg_wr && reg_addr == ADDR_TRIM) begin
         trim_last <= reg_wdata[4:0];
         age <= 0;
      end else if (age < 100000) begin
         age <= age + 1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_trim_rd;
      reg_rd && reg_addr == ADDR_TRIM;
   endsequence
   // mode outside the internal block for four edges
   sequence s_no_mode;
      (primary_mode != PRI_INT_IO1 && primary_mode != PRI_INT_IO2) [*4];
   endsequence
   a_bit5_zero: assert property (s_trim_rd |=> !reg_rdata[5])
      else $error("unused trim bit read as one");
   a_bit6_mode: assert property (s_no_mode ##1 s_trim_rd |=> !reg_rdata[6])
      else $error("multiplier enable readable outside internal mode");
   a_mode_gate: assert property (s_no_mode |-> !mul_run)
      else $error("multiplier runs outside internal mode");
   a_fsel_gate: assert property ((dev_freq_sel != FSEL_8M &&
      dev_freq_sel != FSEL_4M) [*4] |-> !mul_run)
      else $error("multiplier runs at wrong frequency");
   a_mult_four: assert property (dev_mult == (mul_run ? 4'h4 : 4'h1))
      else $error("clock factor does not follow multiplier");
   a_lf_source: assert property (lf_from_fast |-> dev_freq_sel == FSEL_31K)
      else $error("divided fast source outside low select");
   a_sec_run: assert property (power_managed |=> secondary_run)
      else $error("secondary stopped in managed mode");
   a_group_int: assert property (clock_group_sel[1] |=> dev_group == 2'h2)
      else $error("internal group not reported");
   a_slow_clock: assert property (special_from_slow)
      else $error("special features left the slow rc");
   a_hold_lock: assert property (mul_run && $past(mul_run) |-> !exec_hold)
      else $error("execution held after multiplier start");
   a_slow_settle: assert property (age == SLOW_SETTLE_CYC * SLOW_DIV + 3
      |-> slow_rc_trim == trim_last)
      else $error("slow rc trim not settled");
   a_fast_follow: assert property (age == SLOW_SETTLE_CYC * FAST_DIV + 3
      |-> fast_osc_trim == trim_last)
      else $error("fast trim not settled");
endmodule
bind ioscc_top ioscc_top_sva #(.SLOW_DIV(SLOW_DIV), .FAST_DIV(FAST_DIV)) chk_u (.*);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import ioscc_pkg::*;
   logic clk_sys, rstn, reg_wr, reg_rd, power_managed, wake_two_speed;
   logic [3:0] reg_addr, primary_mode, dev_mult;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [1:0] clock_group_sel, dev_group;
   logic [4:0] fast_osc_trim, slow_rc_trim;
   logic [2:0] dev_freq_sel;
   logic mul_run, lf_from_fast, secondary_run, special_from_slow, exec_hold;
   logic rd_seen;
   logic [7:0] exp_q[$];
   logic [31:0] seed;
   int error_cnt, total_checks;
   // short lock and dividers keep the run brief
   ioscc_top #(.LOCK_CYC(4), .SLOW_DIV(4), .FAST_DIV(2)) dut_u (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp_lvl(input logic [7:0] got, input logic [7:0] e);
      total_checks++;
      if (got !== e) begin
         error_cnt++;
         $display("[FAIL] %0t level %h exp %h", $time, got, e);
      end
   endtask
   task automatic cmp_rd(input logic [7:0] got);
      total_checks++;
      if (exp_q.size() == 0 || got !== exp_q[0]) begin
         error_cnt++;
         $display("[FAIL] %0t read %h unexpected", $time, got);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
   task automatic wait_mul(input logic e);
      int i;
      for (i = 0; i < 60 && mul_run !== e; i++) @(negedge clk_sys);
      if (i == 60) begin
         error_cnt++;
         final_report();
      end
      repeat (2) @(negedge clk_sys);
      cmp_lvl({4'h0, dev_mult}, e ? 8'h04 : 8'h01);
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge clk_sys) rd_seen <= reg_rd;
   always @(negedge clk_sys) if (rd_seen) cmp_rd(reg_rdata);
   initial begin
      #1_000_000;
      error_cnt++;
      final_report();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rstn, reg_wr, reg_rd, power_managed, wake_two_speed, rd_seen} = '0;
      {reg_addr, reg_wdata, clock_group_sel} = '0;
      primary_mode = PRI_INT_IO2;
      seed = 32'h3826_9741;
      error_cnt = 0;
      total_checks = 0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(ADDR_TRIM, TRIM_RESET);
      rd(ADDR_CTRL, CTRL_RESET);
      rd(4'hF, 8'h00);
      $display("test reset done");
      wr(ADDR_CTRL, 8'h70);
      wr(ADDR_TRIM, 8'hFF);
      rd(ADDR_TRIM, 8'hDF);
      wait_mul(1'b1);
      wr(ADDR_CTRL, 8'h60);
      repeat (6) @(negedge clk_sys);
      cmp_lvl({7'h0, mul_run}, 8'h01);
      wr(ADDR_CTRL, 8'h50);
      wait_mul(1'b0);
      $display("test frequency gate done");
      @(posedge clk_sys);
      primary_mode <= 4'h2;
      wr(ADDR_CTRL, 8'h70);
      wr(ADDR_TRIM, 8'h4A);
      rd(ADDR_TRIM, 8'h0A);
      repeat (10) @(negedge clk_sys);
      cmp_lvl({7'h0, mul_run}, 8'h00);
      @(posedge clk_sys);
      primary_mode <= PRI_INT_IO1;
      wr(ADDR_TRIM, 8'h00);
      wr(ADDR_TRIM, 8'h40);
      @(posedge clk_sys);
      wake_two_speed <= 1'b1;
      @(posedge clk_sys);
      wake_two_speed <= 1'b0;
      // pending flag, then the registered hold: two edges
      repeat (2) @(negedge clk_sys);
      cmp_lvl({7'h0, exec_hold}, 8'h01);
      wait_mul(1'b1);
      cmp_lvl({7'h0, exec_hold}, 8'h00);
      $display("test mode gate done");
      wr(ADDR_CTRL, 8'h00);
      for (int s = 0; s < 2; s++) begin
         wr(ADDR_TRIM, s ? 8'h00 : 8'h80);
         repeat (3) @(negedge clk_sys);
         cmp_lvl({7'h0, lf_from_fast}, s ? 8'h00 : 8'h01);
      end
      for (int g = 0; g < 4; g++) begin
         @(posedge clk_sys);
         clock_group_sel <= 2'(g);
         power_managed <= (g == 2);
         repeat (3) @(negedge clk_sys);
         cmp_lvl({6'h0, dev_group}, g > 1 ? 8'h02 : 8'(g));
         cmp_lvl({7'h0, secondary_run}, 8'(g == 1 || g == 2));
         cmp_lvl({7'h0, special_from_slow}, 8'h01);
      end
      // software trims down one step, then back up, reading each back
      wr(ADDR_TRIM, 8'h05);
      wr(ADDR_TRIM, 8'h04);
      rd(ADDR_TRIM, 8'h04);
      wr(ADDR_TRIM, 8'h05);
      rd(ADDR_TRIM, 8'h05);
      $display("test sources done");
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         wr(ADDR_TRIM, d);
         rd(ADDR_TRIM, d & 8'hDF);
         repeat (36) @(negedge clk_sys);
         cmp_lvl({3'h0, slow_rc_trim}, {3'h0, d[4:0]});
         cmp_lvl({3'h0, fast_osc_trim}, {3'h0, d[4:0]});
      end
      $display("test random trim done");
      final_report();
   end
endmodule

// ==== logic/ioscc_pkg.sv ====
package ioscc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_TRIM = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h1;
   localparam logic [3:0] ADDR_STAT = 4'h2;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h40;
   localparam int TRIM_SRC_BIT = 7;
   localparam int TRIM_MUL_BIT = 6;
   localparam int TRIM_UNUSED_BIT = 5;
   localparam int TRIM_W = 5;
   localparam int FSEL_LSB = 4;
   // ----------------------------------------
   // modes and selections
   // ----------------------------------------
   localparam logic [3:0] PRI_INT_IO2 = 4'h9;
   localparam logic [3:0] PRI_INT_IO1 = 4'h8;
   localparam logic [2:0] FSEL_8M = 3'h7;
   localparam logic [2:0] FSEL_4M = 3'h6;
   localparam logic [2:0] FSEL_31K = 3'h0;
   localparam int MUL_FACTOR = 4;
   localparam int MUL_MAX_MHZ = 32;
   localparam int LF_DIV = 256;
   localparam int SLOW_SETTLE_CYC = 8;
   // multiplier lock time in ns, counted in 100 MHz cycles
   localparam int CLK_NS = 10;
   localparam int MUL_LOCK_NS = 2000;
   localparam int MUL_LOCK_CYC = (MUL_LOCK_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      IOSCC_SRC_PRIMARY,
      IOSCC_SRC_SECONDARY,
      IOSCC_SRC_INTERNAL
   } ioscc_src_t;
endpackage

// ==== logic/ioscc_settle.sv ====
`timescale 1ns/1ps
module ioscc_settle
   import ioscc_pkg::*;
#(
   parameter int W = 5,
   parameter int STEPS = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic step_en,
   // target and moving value
   input wire logic [W-1:0] target,
   output logic [W-1:0] current,
   output logic settled
);
   // ----------------------------------------
   // one step per enable, toward target
   // ----------------------------------------
   // signed trim walks by half the gap, so any jump lands within STEPS steps
   function automatic logic [W-1:0] approach(input logic [W-1:0] c,
                                            input logic [W-1:0] t);
      logic signed [W:0] d;
      d = $signed({t[W-1], t}) - $signed({c[W-1], c});
      if (d > 1 || d < -1) begin
         approach = W'(c + W'(d >>> 1));
      end else begin
         approach = t;
      end
   endfunction

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         current <= '0;
      end else if (step_en) begin
         current <= approach(current, target);
      end
   end

   assign settled = (current == target);
endmodule

// ==== logic/ioscc_top.sv ====
`timescale 1ns/1ps
// How it works
// - trim write starts oscillators moving immediately
// - slow rc settles within eight own cycles
// - no stall, no shift-done flag
// - multiplier gives four times fast oscillator
// - software enable at trim bit six
// - two-speed wake waits for multiplier start
// - multiplier only in internal primary modes
// - multiplier only at 8 or 4 MHz
// - unavailable enable held zero, reads zero
// - bit seven picks fast/256 or slow rc
// - trim field is two's complement
// - bit five ignores writes, reads zero
// - slow rc trimmed from the same trim field as fast
// - primary, secondary, internal source groups
// - secondary source keeps running when managed
// - slow rc always clocks watchdog, monitor
// - select 111 8M, 110 4M, 000 31k
module ioscc_top
   import ioscc_pkg::*;
#(
   parameter int LOCK_CYC = MUL_LOCK_CYC,
   parameter int SLOW_DIV = 3200,
   parameter int FAST_DIV = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // configuration and system state
   input wire logic [3:0] primary_mode,
   input wire logic [1:0] clock_group_sel,
   input wire logic power_managed,
   input wire logic wake_two_speed,
   // oscillator steering
   output logic [4:0] fast_osc_trim,
   output logic [4:0] slow_rc_trim,
   output logic mul_run,
   output logic [2:0] dev_freq_sel,
   output logic lf_from_fast,
   output logic [3:0] dev_mult,
   output logic [1:0] dev_group,
   output logic secondary_run,
   output logic special_from_slow,
   output logic exec_hold
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic lf_src_reg;
   logic mul_en_reg;
   logic [4:0] trim_value_reg;
   logic [2:0] fsel_reg;
   logic [7:0] rdata_next;
   logic mul_avail;
   logic mul_allowed;
   logic mul_locked;
   logic [$clog2(LOCK_CYC+1)-1:0] lock_cnt_reg;
   logic wake_pend_reg;
   logic [$clog2(SLOW_DIV)-1:0] slow_div_reg;
   logic [$clog2(FAST_DIV)-1:0] fast_div_reg;
   logic slow_tick;
   logic fast_tick;
   logic [4:0] slow_cur;
   logic [4:0] fast_cur;

   function automatic logic is_int_mode(input logic [3:0] m);
      is_int_mode = (m == PRI_INT_IO2) || (m == PRI_INT_IO1);
   endfunction

   function automatic logic is_mul_freq(input logic [2:0] f);
      is_mul_freq = (f == FSEL_8M) || (f == FSEL_4M);
   endfunction

   assign mul_avail = is_int_mode(primary_mode);
   assign mul_allowed = mul_avail && is_mul_freq(fsel_reg);

   // ----------------------------------------
   // trim register writes
   // ----------------------------------------
   // new trim takes effect at once, no busy flag to poll
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         trim_value_reg <= TRIM_RESET[TRIM_W-1:0];
         lf_src_reg <= TRIM_RESET[TRIM_SRC_BIT];
      end else if (reg_wr && reg_addr == ADDR_TRIM) begin
         trim_value_reg <= reg_wdata[TRIM_W-1:0];
         lf_src_reg <= reg_wdata[TRIM_SRC_BIT];
      end
   end

   // enable forced low while the mode cannot use it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mul_en_reg <= TRIM_RESET[TRIM_MUL_BIT];
      end else if (!mul_avail) begin
         mul_en_reg <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_TRIM) begin
         mul_en_reg <= reg_wdata[TRIM_MUL_BIT];
      end
   end

   // frequency select, held here so the multiplier can gate on it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fsel_reg <= CTRL_RESET[FSEL_LSB +: 3];
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         fsel_reg <= reg_wdata[FSEL_LSB +: 3];
      end
   end

   // ----------------------------------------
   // oscillator tick dividers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         slow_div_reg <= '0;
      end else if (slow_tick) begin
         slow_div_reg <= '0;
      end else begin
         slow_div_reg <= slow_div_reg + 1'b1;
      end
   end
   assign slow_tick = (slow_div_reg == ($clog2(SLOW_DIV))'(SLOW_DIV - 1));

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fast_div_reg <= '0;
      end else if (fast_tick) begin
         fast_div_reg <= '0;
      end else begin
         fast_div_reg <= fast_div_reg + 1'b1;
      end
   end
   assign fast_tick = (fast_div_reg == ($clog2(FAST_DIV))'(FAST_DIV - 1));

   // ----------------------------------------
   // independent trim slews
   // ----------------------------------------
   // each oscillator slews on its own tick, so they need not agree
   ioscc_settle #(
      .W(TRIM_W),
      .STEPS(SLOW_SETTLE_CYC)
   ) u_slow (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .step_en(slow_tick),
      .target(trim_value_reg),
      .current(slow_cur),
      .settled()
   );

   ioscc_settle #(
      .W(TRIM_W),
      .STEPS(SLOW_SETTLE_CYC)
   ) u_fast (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .step_en(fast_tick),
      .target(trim_value_reg),
      .current(fast_cur),
      .settled()
   );

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fast_osc_trim <= '0;
         slow_rc_trim <= '0;
      end else begin
         fast_osc_trim <= fast_cur;
         slow_rc_trim <= slow_cur;
      end
   end

   // ----------------------------------------
   // multiplier start-up
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lock_cnt_reg <= '0;
      end else if (!(mul_en_reg && mul_allowed)) begin
         lock_cnt_reg <= '0;
      end else if (!mul_locked) begin
         lock_cnt_reg <= lock_cnt_reg + 1'b1;
      end
   end
   assign mul_locked =
      (lock_cnt_reg == ($clog2(LOCK_CYC+1))'(LOCK_CYC));

   // wake request stays pending until the multiplier has locked
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wake_pend_reg <= 1'b0;
      end else if (wake_two_speed && mul_en_reg && mul_allowed
                   && !mul_locked) begin
         wake_pend_reg <= 1'b1;
      end else if (mul_locked || !(mul_en_reg && mul_allowed)) begin
         wake_pend_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // clock steering outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mul_run <= 1'b0;
         dev_mult <= 4'h1;
         dev_freq_sel <= CTRL_RESET[FSEL_LSB +: 3];
         lf_from_fast <= 1'b0;
         exec_hold <= 1'b0;
      end else begin
         mul_run <= mul_en_reg && mul_allowed && mul_locked;
         if (mul_en_reg && mul_allowed && mul_locked) begin
            dev_mult <= 4'(MUL_FACTOR);
         end else begin
            dev_mult <= 4'h1;
         end
         dev_freq_sel <= fsel_reg;
         lf_from_fast <= (fsel_reg == FSEL_31K) && lf_src_reg;
         exec_hold <= wake_pend_reg && !mul_locked;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dev_group <= IOSCC_SRC_PRIMARY;
         secondary_run <= 1'b0;
         special_from_slow <= 1'b1;
      end else begin
         if (clock_group_sel[1]) begin
            dev_group <= IOSCC_SRC_INTERNAL;
         end else if (clock_group_sel[0]) begin
            dev_group <= IOSCC_SRC_SECONDARY;
         end else begin
            dev_group <= IOSCC_SRC_PRIMARY;
         end
         secondary_run <= clock_group_sel == 2'h1 || power_managed;
         special_from_slow <= 1'b1;
      end
   end

   // ----------------------------------------
   // read back
   // ----------------------------------------
   always_comb begin
      rdata_next = 8'h00;
      if (reg_addr == ADDR_TRIM) begin
         rdata_next[TRIM_SRC_BIT] = lf_src_reg;
         rdata_next[TRIM_MUL_BIT] = mul_en_reg && mul_avail;
         rdata_next[TRIM_UNUSED_BIT] = 1'b0;
         rdata_next[TRIM_W-1:0] = trim_value_reg;
      end else if (reg_addr == ADDR_CTRL) begin
         rdata_next[FSEL_LSB +: 3] = fsel_reg;
      end else if (reg_addr == ADDR_STAT) begin
         rdata_next = {4'h0, mul_avail, mul_run, dev_group};
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule
